// ### pkg/msl_map.svh
`ifndef MSL_MAP_SVH
`define MSL_MAP_SVH
`define MSL_SYNCH_MIN_BITS 4'h8
`define MSL_EOC_CLOCKS 2'h2
`define MSL_DRIBBLE_MAX 3'h5
`define MSL_RECOVER_CLOCKS 6'h28
`define MSL_HEARTBEAT_CLOCKS 7'h40
`define MSL_JAM_BITS 7'h20
`define MSL_PREAMBLE_BITS 7'h40
`endif

// ### pkg/msl_pkg.sv
package msl_pkg;
  typedef enum logic [2:0] {
    MSL_TX_IDLE = 3'b000,
    MSL_TX_PRE = 3'b001,
    MSL_TX_DATA = 3'b010,
    MSL_TX_JAM = 3'b011,
    MSL_TX_HB = 3'b100
  } msl_tx_state_t;
  typedef enum logic [1:0] {
    MSL_RX_IDLE = 2'b00,
    MSL_RX_PRE = 2'b01,
    MSL_RX_DATA = 2'b10,
    MSL_RX_END = 2'b11
  } msl_rx_state_t;
endpackage

// ### core/msl_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser with rising edge flag on the second stage
module msl_edge_sync (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_async,
  output logic o_level,
  output logic o_rise
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic [2:0] arm_reg;
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
      arm_reg <= 3'h0;
    end
    else
    begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
      arm_reg <= {arm_reg[1:0], 1'b1};
    end
  end
  assign o_level = sync_reg;
  // No edge until both stages hold real pin samples after reset
  assign o_rise = sync_reg & ~last_reg & arm_reg[2];
endmodule
`default_nettype wire

// ### core/msl_serial_line.sv
`timescale 1ns/1ps
`default_nettype none
`include "msl_map.svh"
// Operation
// - Transmit enable rises with the first preamble bit, which is a one.
// - First two consecutive ones during preamble mark synch.
// - End of carrier needs carrier low for two receive clocks.
// - Up to five dribble bits after last byte raise no error.
// - End-of-receive processing completes within forty receive clocks.
// - Watch collision 64 transmit clocks after enable drops; else flag heartbeat.
// - On collision finish current byte, then jam within one to eight clocks; in preamble the code jams after the preamble and one full byte.
// - Jam is exactly thirty-two one bits.
module msl_serial_line (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_rx_line_clock,
  input wire logic i_rx_data,
  input wire logic i_carrier_sense_in,
  input wire logic i_tx_line_clock,
  input wire logic i_collision_in,
  input wire logic i_tx_start,
  input wire logic [7:0] i_tx_byte,
  input wire logic i_tx_last,
  output logic o_tx_byte_taken,
  output logic o_tx_line_enable,
  output logic o_tx_data,
  output logic o_heartbeat_missing_flag,
  output logic o_tx_collided,
  output logic o_tx_busy,
  output logic [7:0] o_rx_byte,
  output logic o_rx_byte_valid,
  output logic o_rx_frame_done,
  output logic o_rx_error,
  output logic o_rx_busy
);
  logic rxc_rise;
  logic crs_lvl;
  logic rxd_lvl;
  logic txc_rise;
  logic col_lvl;
  logic rxd_meta_reg;
  logic rxd_sync_reg;
  logic col_meta_reg;
  logic col_sync_reg;
  msl_edge_sync u_rxc (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_async(i_rx_line_clock),
    .o_level(), .o_rise(rxc_rise));
  msl_edge_sync u_crs (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_async(i_carrier_sense_in),
    .o_level(crs_lvl), .o_rise());
  msl_edge_sync u_txc (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_async(i_tx_line_clock),
    .o_level(), .o_rise(txc_rise));
  // Data and collision delayed to match the clock edge path
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rxd_meta_reg <= 1'b0;
      rxd_sync_reg <= 1'b0;
      col_meta_reg <= 1'b0;
      col_sync_reg <= 1'b0;
    end
    else
    begin
      rxd_meta_reg <= i_rx_data;
      rxd_sync_reg <= rxd_meta_reg;
      col_meta_reg <= i_collision_in;
      col_sync_reg <= col_meta_reg;
    end
  end
  assign rxd_lvl = rxd_sync_reg;
  assign col_lvl = col_sync_reg;

  function automatic logic eoc_seen(input logic carrier_sense_in, input logic [1:0] low_cnt);
    eoc_seen = !carrier_sense_in && low_cnt == `MSL_EOC_CLOCKS - 2'h1;
  endfunction

  // Receive side
  msl_pkg::msl_rx_state_t rx_state_reg;
  logic prev_one_reg;
  logic [1:0] crs_low_cnt_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [5:0] rec_cnt_reg;
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rx_state_reg <= msl_pkg::MSL_RX_IDLE;
      prev_one_reg <= 1'b0;
      crs_low_cnt_reg <= 2'h0;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      rec_cnt_reg <= 6'h00;
      o_rx_byte <= 8'h00;
      o_rx_byte_valid <= 1'b0;
      o_rx_frame_done <= 1'b0;
      o_rx_error <= 1'b0;
      o_rx_busy <= 1'b0;
    end
    else
    begin
      o_rx_byte_valid <= 1'b0;
      o_rx_frame_done <= 1'b0;
      if (rxc_rise)
      begin
        if (crs_lvl)
          crs_low_cnt_reg <= 2'h0;
        else if (crs_low_cnt_reg != `MSL_EOC_CLOCKS)
          crs_low_cnt_reg <= crs_low_cnt_reg + 2'h1;
        case (rx_state_reg)
          msl_pkg::MSL_RX_IDLE:
          begin
            prev_one_reg <= 1'b0;
            if (crs_lvl)
            begin
              rx_state_reg <= msl_pkg::MSL_RX_PRE;
              o_rx_busy <= 1'b1;
              o_rx_error <= 1'b0;
              prev_one_reg <= rxd_lvl;
            end
          end
          msl_pkg::MSL_RX_PRE:
          begin
            prev_one_reg <= rxd_lvl;
            if (eoc_seen(crs_lvl, crs_low_cnt_reg))
            begin
              rx_state_reg <= msl_pkg::MSL_RX_END;
              rec_cnt_reg <= 6'h00;
            end
            else if (prev_one_reg && rxd_lvl)
            begin
              rx_state_reg <= msl_pkg::MSL_RX_DATA;
              bit_cnt_reg <= 3'h0;
            end
          end
          msl_pkg::MSL_RX_DATA:
          begin
            if (eoc_seen(crs_lvl, crs_low_cnt_reg))
            begin
              // Partial byte is dribble; tolerated up to the limit
              o_rx_error <= (bit_cnt_reg > `MSL_DRIBBLE_MAX);
              rx_state_reg <= msl_pkg::MSL_RX_END;
              rec_cnt_reg <= 6'h00;
            end
            else if (crs_lvl || crs_low_cnt_reg != 2'h0)
            begin
              shift_reg <= {rxd_lvl, shift_reg[7:1]};
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == 3'h7)
              begin
                o_rx_byte <= {rxd_lvl, shift_reg[7:1]};
                o_rx_byte_valid <= 1'b1;
              end
            end
          end
          msl_pkg::MSL_RX_END:
          begin
            rec_cnt_reg <= rec_cnt_reg + 6'h01;
            if (rec_cnt_reg == 6'h00)
              o_rx_frame_done <= 1'b1;
            if (rec_cnt_reg == `MSL_RECOVER_CLOCKS - 6'h01 || rec_cnt_reg == 6'h03)
            begin
              rx_state_reg <= msl_pkg::MSL_RX_IDLE;
              o_rx_busy <= 1'b0;
            end
          end
          default: rx_state_reg <= msl_pkg::MSL_RX_IDLE;
        endcase
      end
    end
  end

  // Transmit side
  msl_pkg::msl_tx_state_t tx_state_reg;
  logic [6:0] tx_cnt_reg;
  logic [7:0] tx_shift_reg;
  logic tx_last_reg;
  logic col_seen_reg;
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      tx_state_reg <= msl_pkg::MSL_TX_IDLE;
      tx_cnt_reg <= 7'h00;
      tx_shift_reg <= 8'h00;
      tx_last_reg <= 1'b0;
      col_seen_reg <= 1'b0;
      o_tx_line_enable <= 1'b0;
      o_tx_data <= 1'b0;
      o_tx_byte_taken <= 1'b0;
      o_heartbeat_missing_flag <= 1'b0;
      o_tx_collided <= 1'b0;
      o_tx_busy <= 1'b0;
    end
    else
    begin
      o_tx_byte_taken <= 1'b0;
      if (col_lvl && tx_state_reg != msl_pkg::MSL_TX_IDLE && tx_state_reg != msl_pkg::MSL_TX_HB)
        col_seen_reg <= 1'b1;
      if (txc_rise)
      begin
        case (tx_state_reg)
          msl_pkg::MSL_TX_IDLE:
          begin
            o_tx_line_enable <= 1'b0;
            o_tx_data <= 1'b0;
            if (i_tx_start)
            begin
              tx_state_reg <= msl_pkg::MSL_TX_PRE;
              o_tx_line_enable <= 1'b1;
              o_tx_data <= 1'b1;
              tx_cnt_reg <= 7'h01;
              col_seen_reg <= 1'b0;
              o_tx_collided <= 1'b0;
              o_heartbeat_missing_flag <= 1'b0;
              o_tx_busy <= 1'b1;
            end
          end
          msl_pkg::MSL_TX_PRE:
          begin
            // Alternating preamble ending in 11 synch
            o_tx_data <= (tx_cnt_reg == `MSL_PREAMBLE_BITS - 7'h01) ? 1'b1 : ~tx_cnt_reg[0];
            tx_cnt_reg <= tx_cnt_reg + 7'h01;
            if (tx_cnt_reg == `MSL_PREAMBLE_BITS - 7'h01)
            begin
              tx_state_reg <= msl_pkg::MSL_TX_DATA;
              tx_shift_reg <= i_tx_byte;
              tx_last_reg <= i_tx_last;
              o_tx_byte_taken <= 1'b1;
              tx_cnt_reg <= 7'h00;
            end
          end
          msl_pkg::MSL_TX_DATA:
          begin
            o_tx_data <= tx_shift_reg[0];
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            tx_cnt_reg <= tx_cnt_reg + 7'h01;
            if (tx_cnt_reg[2:0] == 3'h7)
            begin
              tx_cnt_reg <= 7'h00;
              if (col_seen_reg || col_lvl)
              begin
                tx_state_reg <= msl_pkg::MSL_TX_JAM;
                o_tx_collided <= 1'b1;
              end
              else if (tx_last_reg)
                tx_state_reg <= msl_pkg::MSL_TX_JAM;
              else
              begin
                tx_shift_reg <= i_tx_byte;
                tx_last_reg <= i_tx_last;
                o_tx_byte_taken <= 1'b1;
              end
            end
          end
          msl_pkg::MSL_TX_JAM:
          begin
            if (o_tx_collided && tx_cnt_reg != `MSL_JAM_BITS)
            begin
              o_tx_data <= 1'b1;
              tx_cnt_reg <= tx_cnt_reg + 7'h01;
            end
            else
            begin
              o_tx_line_enable <= 1'b0;
              o_tx_data <= 1'b0;
              tx_state_reg <= msl_pkg::MSL_TX_HB;
              tx_cnt_reg <= 7'h00;
              col_seen_reg <= 1'b0;
            end
          end
          msl_pkg::MSL_TX_HB:
          begin
            tx_cnt_reg <= tx_cnt_reg + 7'h01;
            if (col_lvl)
              col_seen_reg <= 1'b1;
            if (tx_cnt_reg == `MSL_HEARTBEAT_CLOCKS - 7'h01)
            begin
              o_heartbeat_missing_flag <= ~(col_seen_reg | col_lvl);
              tx_state_reg <= msl_pkg::MSL_TX_IDLE;
              o_tx_busy <= 1'b0;
            end
          end
          default: tx_state_reg <= msl_pkg::MSL_TX_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/msl_serial_line_chk.sv
`timescale 1ns/1ps
`default_nettype none
module msl_serial_line_chk (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_rx_line_clock,
  input wire logic i_carrier_sense_in,
  input wire logic i_tx_line_clock,
  input wire logic i_collision_in,
  input wire logic o_tx_line_enable,
  input wire logic o_tx_data,
  input wire logic o_heartbeat_missing_flag,
  input wire logic o_tx_collided,
  input wire logic o_tx_busy,
  input wire logic o_rx_frame_done,
  input wire logic o_rx_error,
  input wire logic o_rx_busy
);
  logic [2:0] tc_reg;
  logic [2:0] rc_reg;
  logic [7:0] hb_reg;
  logic [7:0] jam_reg;
  logic [3:0] low_reg;
  logic col_reg;
  logic hit_reg;
  wire logic tx_rise = tc_reg[1] & ~tc_reg[2];
  wire logic rx_rise = rc_reg[1] & ~rc_reg[2];
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      {tc_reg, rc_reg, hb_reg, jam_reg, low_reg, col_reg, hit_reg} <= '0;
    end
    else
    begin
      tc_reg <= {tc_reg[1:0], i_tx_line_clock};
      rc_reg <= {rc_reg[1:0], i_rx_line_clock};
      // Clocks since enable dropped, and any collision seen then
      hb_reg <= o_tx_line_enable ? 8'h00 : hb_reg + {7'h00, tx_rise && hb_reg != 8'hFF};
      col_reg <= !o_tx_line_enable && (col_reg || i_collision_in);
      hit_reg <= o_tx_line_enable && (hit_reg || i_collision_in);
      jam_reg <= hit_reg ? jam_reg + {7'h00, tx_rise} : 8'h00;
      low_reg <= i_carrier_sense_in ? 4'h0 : low_reg + {3'h0, rx_rise && low_reg != 4'hF};
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  first_one_a: assert property ($rose(o_tx_line_enable) |-> o_tx_data)
    else $error("first preamble bit not one");
  first_hold_a: assert property ($rose(o_tx_line_enable) |-> o_tx_data [*8])
    else $error("first preamble bit too short");
  hb_window_a: assert property ($fell(o_tx_busy) |-> hb_reg >= 8'h3E && hb_reg <= 8'h42)
    else $error("heartbeat window length off");
  hb_flag_a: assert property ($rose(o_heartbeat_missing_flag) |-> hb_reg >= 8'h3E)
    else $error("heartbeat flag set early");
  hb_clean_a: assert property ($rose(o_heartbeat_missing_flag) |-> !col_reg)
    else $error("heartbeat flag despite collision");
  jam_span_a: assert property ($fell(o_tx_line_enable) && hit_reg |-> jam_reg >= 8'h20 && jam_reg <= 8'h2B)
    else $error("jam timing off");
  eoc_wait_a: assert property (o_rx_frame_done |-> low_reg >= 4'h2)
    else $error("frame end before carrier low two clocks");
  rx_recover_a: assert property ($rose(o_rx_frame_done) |-> ##[0:660] !o_rx_busy)
    else $error("receive recovery too long");
  cover property ($rose(o_tx_collided));
  cover property ($rose(o_heartbeat_missing_flag));
  cover property ($rose(o_rx_error));
endmodule
bind msl_serial_line msl_serial_line_chk u_msl_serial_line_chk (.i_clk, .i_reset_n, .i_rx_line_clock,
  .i_carrier_sense_in, .i_tx_line_clock, .i_collision_in, .o_tx_line_enable, .o_tx_data,
  .o_heartbeat_missing_flag, .o_tx_collided, .o_tx_busy, .o_rx_frame_done, .o_rx_error, .o_rx_busy);
`default_nettype wire

// ### tb/msl_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module msl_phy_model (
  input wire logic i_tx_line_enable,
  input wire logic i_tx_data,
  output logic o_tx_line_clock,
  output logic o_rx_line_clock,
  output logic o_rx_data,
  output logic o_carrier_sense_in,
  output logic o_collision_in
);
  logic tx_bits [0:255];
  int tx_n = 0;
  int col_at = 0;
  logic hb_on = 1'b1;
  initial
  begin
    {o_rx_line_clock, o_rx_data, o_carrier_sense_in, o_collision_in, o_tx_line_clock} = 5'h00;
    forever #80 o_tx_line_clock = ~o_tx_line_clock;
  end
  always @(posedge o_tx_line_clock)
  begin
    if (i_tx_line_enable === 1'b1)
    begin
      tx_bits[tx_n] = i_tx_data;
      tx_n = tx_n + 1;
    end
  end
  task automatic col_pulse;
    @(posedge o_tx_line_clock);
    #1 col_at = tx_n;
    #4 o_collision_in = 1'b1;
    repeat (2) @(posedge o_tx_line_clock);
    #5 o_collision_in = 1'b0;
  endtask
  // Heartbeat after any fall that follows a rise, so not the power-up reset fall
  always
  begin
    @(posedge i_tx_line_enable);
    @(negedge i_tx_line_enable);
    if (hb_on)
    begin
      repeat (5) @(posedge o_tx_line_clock);
      #5 o_collision_in = 1'b1;
      repeat (2) @(posedge o_tx_line_clock);
      #5 o_collision_in = 1'b0;
    end
  end
  task automatic rx_bit(input logic v);
    o_rx_data = v;
    #80 o_rx_line_clock = 1'b1;
    #80 o_rx_line_clock = 1'b0;
  endtask
  // Clock only runs once carrier is up, so no unlocked bits enter
  task automatic rx_frame(input logic [15:0] d, input int drib);
    o_carrier_sense_in = 1'b1;
    for (int i = 0; i < 12; i++) rx_bit(i > 9 || !i[0]);
    for (int i = 0; i < 16; i++) rx_bit(d[i]);
    for (int i = 0; i < drib; i++) rx_bit(i[0]);
    o_carrier_sense_in = 1'b0;
    for (int i = 0; i < 8; i++) rx_bit(~o_rx_data);
    o_rx_data = ~o_rx_data;
  endtask
endmodule
`default_nettype wire

// ### tb/msl_serial_line_tb.sv
`timescale 1ns/1ps
`default_nettype none
module msl_serial_line_tb;
  logic clk, reset_n, tx_start, tx_last;
  logic [7:0] tx_byte;
  wire logic tx_clk, rx_clk, rx_data, carrier_sense_in, col, taken, tx_en, tx_data, hb_flag, collided, tx_busy;
  wire logic rx_valid, rx_done, rx_err, rx_busy;
  wire logic [7:0] rx_byte;
  int err_total = 0;
  int comparisons = 0;
  logic [7:0] rx_q [$];
  msl_serial_line u_msl_serial_line (.i_clk(clk), .i_reset_n(reset_n), .i_rx_line_clock(rx_clk),
    .i_rx_data(rx_data), .i_carrier_sense_in(carrier_sense_in), .i_tx_line_clock(tx_clk), .i_collision_in(col),
    .i_tx_start(tx_start), .i_tx_byte(tx_byte), .i_tx_last(tx_last), .o_tx_byte_taken(taken),
    .o_tx_line_enable(tx_en), .o_tx_data(tx_data), .o_heartbeat_missing_flag(hb_flag),
    .o_tx_collided(collided), .o_tx_busy(tx_busy), .o_rx_byte(rx_byte), .o_rx_byte_valid(rx_valid),
    .o_rx_frame_done(rx_done), .o_rx_error(rx_err), .o_rx_busy(rx_busy));
  msl_phy_model u_msl_phy_model (.i_tx_line_enable(tx_en), .i_tx_data(tx_data), .o_tx_line_clock(tx_clk),
    .o_rx_line_clock(rx_clk), .o_rx_data(rx_data), .o_carrier_sense_in(carrier_sense_in), .o_collision_in(col));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (rx_valid === 1'b1) rx_q.push_back(rx_byte);
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic late(input logic ok);
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("wrong value at %0t: wait ran out", $time);
      complete_run;
    end
  endtask
  task automatic tx_drive(input logic [15:0] d, input int n);
    int k;
    k = 0;
    u_msl_phy_model.tx_n = 0;
    {tx_byte, tx_last, tx_start} = {d[7:0], n == 1, 1'b1};
    for (int t = 0; t < 3000 && k < n; t++)
    begin
      tick;
      if (taken === 1'b1)
      begin
        k++;
        {tx_byte, tx_last, tx_start} = {d[15:8], 2'b10};
      end
    end
    late(k == n);
    for (int t = 0; t < 4000 && tx_busy !== 1'b0; t++) tick;
    late(tx_busy === 1'b0);
  endtask
  task automatic sc_tx_plain;
    u_msl_phy_model.hb_on = 1'b1;
    tx_drive(16'hC35A, 2);
    chk(u_msl_phy_model.tx_n, 8'h50);
    for (int i = 0; i < 80; i++)
      chk(u_msl_phy_model.tx_bits[i], i < 64 ? (i == 63 || !i[0]) : 16'hC35A >> (i - 64) & 1);
    chk(hb_flag, 8'h00);
  endtask
  task automatic sc_tx_nohb;
    u_msl_phy_model.hb_on = 1'b0;
    tx_drive(16'h0081, 1);
    chk(hb_flag, 8'h01);
  endtask
  task automatic sc_tx_col;
    u_msl_phy_model.hb_on = 1'b1;
    u_msl_phy_model.tx_n = 0;
    fork
      tx_drive(16'h00F0, 1);
      begin
        for (int t = 0; t < 3000 && u_msl_phy_model.tx_n < 66; t++) tick;
        u_msl_phy_model.col_pulse;
      end
    join
    chk(u_msl_phy_model.col_at, 8'h43);
    chk(u_msl_phy_model.tx_n, 8'h68);
    for (int i = 64; i < 104; i++) chk(u_msl_phy_model.tx_bits[i], i > 67);
    chk({collided, hb_flag}, 8'h02);
  endtask
  task automatic sc_rx(input int drib, input logic err);
    rx_q.delete();
    u_msl_phy_model.rx_frame(16'h3CA5, drib);
    for (int t = 0; t < 700 && rx_busy !== 1'b0; t++) tick;
    late(rx_busy === 1'b0);
    chk(rx_q.size(), 8'h02);
    chk(rx_q[0], 8'hA5);
    chk(rx_q[1], 8'h3C);
    chk(rx_err, err);
  endtask
  task automatic sc_reset;
    {tx_byte, tx_last, tx_start} = {8'h55, 2'b11};
    for (int t = 0; t < 400 && tx_en !== 1'b1; t++) tick;
    late(tx_en === 1'b1);
    {reset_n, tx_start} = 2'b00;
    tick;
    chk({tx_en, tx_data}, 8'h00);
    repeat (128) tick;
    chk({tx_busy, tx_en, tx_data}, 8'h00);
    reset_n = 1'b1;
    repeat (3) tick;
  endtask
  initial
  begin
    {reset_n, tx_start, tx_last, tx_byte} = 11'h000;
    repeat (3) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (3) tick;
    sc_tx_plain;
    sc_tx_nohb;
    sc_tx_col;
    sc_rx(6, 1'b1);
    sc_rx(5, 1'b0);
    sc_reset;
    sc_tx_nohb;
    complete_run;
  end
endmodule
`default_nettype wire
